// file: rtl/daco_ctrl.sv
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
module daco_ctrl
  import daco_pkg::*;
#(
  parameter int SCAN_CYC = SCAN_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  daco_if.ctrl link,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8+:8] = nv[b*8+:8];
      end
    end
    return r;
  endfunction : merge

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic [31:0] ctrl_q, ctrl_d;
  logic [CODE_W-1:0] data_q [CH];
  logic [CODE_W-1:0] data_d [CH];
  logic [ADDR_W-1:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic awHave_q, awHave_d, wHave_q, wHave_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic doWrite;
  logic busy;
  logic [15:0] scanCount_q, scanCount_d;

  assign doWrite = awHave_q && wHave_q && !bvalid_q;

  always_comb begin
    ctrl_d = ctrl_q;
    data_d = data_q;
    awAddr_d = awAddr_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    awHave_d = awHave_q;
    wHave_d = wHave_q;
    bvalid_d = bvalid_q && !bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !rready;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (awvalid && awready_q) begin
      awAddr_d = awaddr;
      awHave_d = 1'b1;
    end
    if (wvalid && wready_q) begin
      wData_d = wdata;
      wStrb_d = wstrb;
      wHave_d = 1'b1;
    end
    if (doWrite) begin
      awHave_d = 1'b0;
      wHave_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      if (awAddr_q[7:2] == REG_CTRL[7:2]) begin
        ctrl_d = merge(ctrl_q, wData_q, wStrb_q);
      end else if (awAddr_q[7:5] == REG_DATA0[7:5]) begin
        data_d[awAddr_q[4:2]] = CODE_W'(merge(32'(data_q[awAddr_q[4:2]]), wData_q, wStrb_q));
      end else if (awAddr_q[7:2] != REG_STATUS[7:2]) begin
        bresp_d = RESP_SLVERR;
      end
    end
    if (arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (araddr[7:2] == REG_CTRL[7:2]) begin
        rdata_d = ctrl_q;
      end else if (araddr[7:2] == REG_STATUS[7:2]) begin
        rdata_d[STAT_SCAN_LSB+:16] = scanCount_q;
        rdata_d[STAT_BUSY] = busy;
      end else if (araddr[7:5] == REG_DATA0[7:5]) begin
        rdata_d[CODE_W-1:0] = data_q[araddr[4:2]];
      end else begin
        rresp_d = RESP_SLVERR;
      end
    end
    awready_d = !awHave_d;
    wready_d = !wHave_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_q <= CTRL_RESET;
      for (int i = 0; i < CH; i++) begin
        data_q[i] <= CODE_RESET;
      end
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      data_q <= data_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      awHave_q <= awHave_d;
      wHave_q <= wHave_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;

  // ****************************************************************
  // Scan engine
  // ****************************************************************
  // A scan that is still sending when the timer expires skips that slot, so scans
  // never overlap at the device.
  daco_state_t state_q, state_d;
  logic [31:0] timer_q, timer_d;
  logic [SEL_W-1:0] chan_q, chan_d, left_q, left_d, muxPtr_q, muxPtr_d, lastChan;
  logic [WORD_W-1:0] word_q, word_d;
  logic valid_q, valid_d, start_q, start_d, scanDue;

  assign scanDue = (timer_q == 32'h0000_0000);
  assign lastChan = ctrl_q[CTRL_CNT_LSB+:SEL_W];
  assign busy = (state_q == DACO_SEND);

  function automatic logic [WORD_W-1:0] pack(input logic en, input logic [SEL_W-1:0] ch,
                                             input logic [CODE_W-1:0] code);
    return {en, ch, code};
  endfunction : pack

  always_comb begin
    state_d = state_q;
    timer_d = scanDue ? 32'(SCAN_CYC - 1) : timer_q - 32'h0000_0001;
    chan_d = chan_q;
    left_d = left_q;
    muxPtr_d = muxPtr_q;
    word_d = word_q;
    valid_d = valid_q;
    start_d = 1'b0;
    scanCount_d = scanCount_q;
    case (state_q)
      DACO_IDLE: begin
        if (scanDue && ctrl_q[CTRL_RUN]) begin
          state_d = DACO_SEND;
          start_d = 1'b1;
          scanCount_d = scanCount_q + 16'h0001;
          chan_d = ctrl_q[CTRL_PTR] ? 3'h0 : muxPtr_q;
          left_d = ctrl_q[CTRL_PTR] ? lastChan : 3'h0;
          word_d = pack(ctrl_q[CTRL_EN], chan_d, data_q[chan_d]);
          valid_d = 1'b1;
        end
      end
      DACO_SEND: begin
        if (valid_q && link.pointReady) begin
          if (left_q == 3'h0) begin
            state_d = DACO_IDLE;
            valid_d = 1'b0;
            if (!ctrl_q[CTRL_PTR]) begin
              muxPtr_d = (muxPtr_q >= lastChan) ? 3'h0 : muxPtr_q + 3'h1;
            end
          end else begin
            chan_d = chan_q + 3'h1;
            left_d = left_q - 3'h1;
            word_d = pack(ctrl_q[CTRL_EN], chan_d, data_q[chan_d]);
          end
        end
      end
      default: begin
        state_d = DACO_IDLE;
        valid_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= DACO_IDLE;
      timer_q <= 32'h0000_0000;
      chan_q <= 3'h0;
      left_q <= 3'h0;
      muxPtr_q <= 3'h0;
      word_q <= 16'h0000;
      valid_q <= 1'b0;
      start_q <= 1'b0;
      scanCount_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      chan_q <= chan_d;
      left_q <= left_d;
      muxPtr_q <= muxPtr_d;
      word_q <= word_d;
      valid_q <= valid_d;
      start_q <= start_d;
      scanCount_q <= scanCount_d;
    end
  end

  assign link.pointWord = word_q;
  assign link.pointValid = valid_q;
  assign link.scanStart = start_q;

endmodule : daco_ctrl

// file: common/daco_pkg.sv
package daco_pkg;

  // ****************************************************************
  // Control word layout
  // ****************************************************************
  localparam int CH = 8;
  localparam int CODE_W = 12;
  localparam int SEL_W = 3;
  localparam int WORD_W = 16;
  localparam int SEL_LSB = 12;
  localparam int EN_BIT = 15;
  localparam int BUF_DEPTH = 2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 25_000_000;
  localparam real REFRESH_MS = 4.5;
  localparam real LATENCY_MAX_MS = 9.0;
  localparam int REFRESH_CYCLES = int'($ceil(REFRESH_MS * CLK_HZ / 1000.0));
  localparam real SCAN_MS = 1.0;
  localparam int SCAN_CYCLES = int'($ceil(SCAN_MS * CLK_HZ / 1000.0));

  // ****************************************************************
  // Controller registers
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_DATA0 = 8'h20;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_PTR = 1;
  localparam int CTRL_EN = 2;
  localparam int CTRL_CNT_LSB = 4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_SCAN_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0074;
  localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {DACO_IDLE, DACO_SEND} daco_state_t;

endpackage : daco_pkg

// file: common/daco_if.sv
`timescale 1ns/1ns
interface daco_if;
  logic scanStart;
  logic [15:0] pointWord;
  logic pointValid;
  logic pointReady;

  modport ctrl (
    output scanStart,
    output pointWord,
    output pointValid,
    input pointReady
  );

  modport dev (
    input scanStart,
    input pointWord,
    input pointValid,
    output pointReady
  );
endinterface : daco_if

// file: rtl/daco_device.sv
`timescale 1ns/1ns
// How it works
// - Sixteen points: 12 data, 3 select, 1 enable.
// - Multiplexed: one channel gets new data per scan.
// - Pointer mode: up to eight channels per scan.
// - Jumper installed gives 0-5 V, removed 0-10 V.
// - Control word sits whole within one word.
// - Every output refreshed from held values each refresh tick.
// - Single channel may be updated every scan.
// - Written value reaches output within 4.5-9.0 ms.
// - Select value 0..7 chooses channel 1..8.
// - Low twelve bits are the straight binary code.
// - Enable off clears outputs; on lets them update.
module daco_device
  import daco_pkg::*;
#(
  parameter int REFRESH_CYC = REFRESH_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  daco_if.dev link,
  input wire logic rangeJumperIn,
  output logic [CH-1:0][CODE_W-1:0] fieldCode,
  output logic rangeTenVolt,
  output logic outputsOn,
  output logic refreshTick
);

  // ****************************************************************
  // Two-entry word buffer
  // ****************************************************************
  logic [WORD_W-1:0] buf_q [BUF_DEPTH];
  logic [WORD_W-1:0] buf_d [BUF_DEPTH];
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic ready_q;
  logic ready_d;
  logic [31:0] refCnt_q;
  logic [31:0] refCnt_d;
  logic tickNow;
  logic push;
  logic pop;
  logic [WORD_W-1:0] head;
  logic [SEL_W-1:0] headSel;
  logic headEn;
  logic [CODE_W-1:0] headCode;
  logic on_q;
  logic on_d;
  logic range_q;
  logic tick_q;

  assign tickNow = (refCnt_q == 32'h0000_0000);
  assign push = link.pointValid && ready_q;
  // The buffer is not drained in the refresh cycle, so a burst of words can fill it
  // and hold the controller off through pointReady.
  assign pop = (cnt_q != 2'h0) && !tickNow;
  assign head = buf_q[0];
  assign headCode = head[CODE_W-1:0];
  assign headSel = head[SEL_LSB+SEL_W-1:SEL_LSB];
  assign headEn = head[EN_BIT];

  always_comb begin
    buf_d = buf_q;
    cnt_d = cnt_q;
    if (pop) begin
      buf_d[0] = buf_q[1];
      cnt_d = cnt_q - 2'h1;
    end
    if (push) begin
      buf_d[cnt_d[0]] = link.pointWord;
      cnt_d = cnt_d + 2'h1;
    end
    ready_d = (cnt_d != 2'(BUF_DEPTH));
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      buf_q[0] <= 16'h0000;
      buf_q[1] <= 16'h0000;
      cnt_q <= 2'h0;
      ready_q <= 1'b0;
    end else begin
      buf_q <= buf_d;
      cnt_q <= cnt_d;
      ready_q <= ready_d;
    end
  end

  // ****************************************************************
  // Refresh timer and status
  // ****************************************************************
  always_comb begin
    refCnt_d = tickNow ? 32'(REFRESH_CYC - 1) : refCnt_q - 32'h0000_0001;
    on_d = on_q;
    if (pop) begin
      on_d = headEn;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      refCnt_q <= 32'h0000_0000;
      on_q <= 1'b0;
      range_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      refCnt_q <= refCnt_d;
      on_q <= on_d;
      range_q <= !rangeJumperIn;
      tick_q <= tickNow;
    end
  end

  assign link.pointReady = ready_q;
  assign outputsOn = on_q;
  assign rangeTenVolt = range_q;
  assign refreshTick = tick_q;

  // ****************************************************************
  // Per-channel held, pending and field values
  // ****************************************************************
  // A value passes held -> pending -> field on two refresh ticks. This fixes the
  // write-to-output delay between one and two refresh periods.
  logic [CODE_W-1:0] held_q [CH];
  logic [CODE_W-1:0] pend_q [CH];
  logic [CODE_W-1:0] out_q [CH];

  for (genvar g = 0; g < CH; g++) begin : gChan
    logic [CODE_W-1:0] heldD;
    logic [CODE_W-1:0] pendD;
    logic [CODE_W-1:0] outD;

    always_comb begin
      heldD = held_q[g];
      pendD = pend_q[g];
      outD = out_q[g];
      if (pop && headEn && (headSel == SEL_W'(g))) begin
        heldD = headCode;
      end
      if (pop && !headEn) begin
        heldD = CODE_RESET;
        pendD = CODE_RESET;
        outD = CODE_RESET;
      end else if (tickNow) begin
        pendD = held_q[g];
        outD = pend_q[g];
      end
    end

    always_ff @(posedge mclk) begin
      if (reset) begin
        held_q[g] <= CODE_RESET;
        pend_q[g] <= CODE_RESET;
        out_q[g] <= CODE_RESET;
      end else begin
        held_q[g] <= heldD;
        pend_q[g] <= pendD;
        out_q[g] <= outD;
      end
    end

    assign fieldCode[g] = out_q[g];
  end

endmodule : daco_device

// file: test/daco_sva.sv
`timescale 1ns/1ns
module daco_sva (
  input wire logic mclk,
  input wire logic reset,
  input wire logic scanStart,
  input wire logic [15:0] pointWord,
  input wire logic pointValid,
  input wire logic pointReady
);
  // ****************************************************************
  // Scan tracking
  // ****************************************************************
  // Only the link is visible here, so the mode is inferred from traffic.
  // A lone word per scan makes the step check vacuous.
  logic take;
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] sel_q, sel_d;
  assign take = pointValid && pointReady;
  always_comb begin
    cnt_d = scanStart ? 4'h0 : cnt_q;
    sel_d = sel_q;
    if (take) begin
      cnt_d = cnt_d + 4'h1;
      sel_d = pointWord[14:12];
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_q <= 4'h0;
      sel_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
      sel_q <= sel_d;
    end
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  a_valid_held: assert property (
    pointValid && !pointReady |=> pointValid && $stable(pointWord))
    else $error("point word changed before it was taken");
  a_scan_opens: assert property (
    $rose(pointValid) |-> scanStart)
    else $error("word offered outside a scan start");
  a_scan_pulse: assert property (
    scanStart |=> !scanStart [*8])
    else $error("scan start pulses too close");
  a_scan_cap: assert property (
    cnt_q <= 4'h8)
    else $error("more than eight words in one scan");
  a_sel_step: assert property (
    take && !scanStart && cnt_q != 4'h0 |-> pointWord[14:12] == sel_q + 3'h1)
    else $error("channel select did not step by one");
  a_ready_wake: assert property (
    $fell(reset) |=> pointReady)
    else $error("ready not raised after reset");
  a_ready_cause: assert property (
    $fell(pointReady) |-> $past(take))
    else $error("ready fell without a word taken");
  a_valid_drop: assert property (
    $fell(pointValid) |-> $past(take))
    else $error("valid dropped before its word was taken");
  c_full_scan: cover property (take && cnt_q == 4'h7);
  c_stall: cover property (pointValid && !pointReady);
  c_disable: cover property (take && !pointWord[15]);
  c_open: cover property ($rose(pointValid));
endmodule : daco_sva

// file: test/daco_test.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    cmp_count++; \
    if ((got) !== (ex)) begin \
      failures++; \
      $display("Error %s expected %h seen %h", nm, ex, got); \
    end \
  end
module daco_test
  import daco_pkg::*;
;
  localparam int RFR = 20;
  // The scan period is kept off a multiple of the refresh period, so that refresh
  // cycles fall inside scans and the link really stalls.
  localparam int SCN = 46;
  localparam int LAT = 2 * RFR + 8 * SCN + 40;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic rangeJumperIn = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [CH-1:0][CODE_W-1:0] fieldCode;
  logic rangeTenVolt, outputsOn, refreshTick;
  logic [CODE_W-1:0] expCode [CH];
  logic [15:0] seed = 16'h000d;
  logic steady = 1'b0;
  int failures = 0;
  int cmp_count = 0;
  daco_if link ();
  daco_ctrl #(.SCAN_CYC(SCN)) i_daco_ctrl (.mclk(mclk), .reset(reset), .link(link),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  daco_device #(.REFRESH_CYC(RFR)) i_daco_device (.mclk(mclk), .reset(reset), .link(link),
    .rangeJumperIn(rangeJumperIn), .fieldCode(fieldCode), .rangeTenVolt(rangeTenVolt),
    .outputsOn(outputsOn), .refreshTick(refreshTick));
  daco_sva i_daco_sva (.mclk(mclk), .reset(reset), .scanStart(link.scanStart),
    .pointWord(link.pointWord), .pointValid(link.pointValid), .pointReady(link.pointReady));
  always #20 mclk = ~mclk;
  logic [2:0] seenSel;
  logic [12:0] seenWord;
  assign seenSel = link.pointWord[14:12];
  assign seenWord = {link.pointWord[15], link.pointWord[11:0]};
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  function automatic logic [31:0] ctrl_word(input logic run, input logic ptr, input logic en,
                                            input logic [2:0] last);
    logic [31:0] v;
    v = '0;
    v[CTRL_RUN] = run;
    v[CTRL_PTR] = ptr;
    v[CTRL_EN] = en;
    v[CTRL_CNT_LSB +: 3] = last;
    return v;
  endfunction : ctrl_word
  function automatic logic [ADDR_W-1:0] data_addr(input int i);
    return ADDR_W'(int'(REG_DATA0) + 4 * i);
  endfunction : data_addr
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    int n;
    logic aw, w;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (n < 1000) begin
      @(posedge mclk);
      n++;
      if (aw && w && bvalid) break;
      if (awready && !aw) begin
        awvalid <= 1'b0;
        aw = 1'b1;
      end
      if (wready && !w) begin
        wvalid <= 1'b0;
        w = 1'b1;
      end
      if (aw && w) bready <= 1'b1;
    end
    bready <= 1'b0;
    r = bresp;
    if (n >= 1000) failures++;
  endtask : axi_wr
  task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar;
    n = 0;
    ar = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (n < 1000) begin
      @(posedge mclk);
      n++;
      if (ar && rvalid) break;
      if (arready && !ar) begin
        arvalid <= 1'b0;
        rready <= 1'b1;
        ar = 1'b1;
      end
    end
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (n >= 1000) failures++;
  endtask : axi_rd
  // Polls under a bound so a lost update fails instead of hanging.
  task automatic wait_code(input int ch, input logic [CODE_W-1:0] c, input int lim);
    int n;
    n = 0;
    while (fieldCode[ch] !== c && n < lim) begin
      @(posedge mclk);
      n++;
    end
    `CHK("fieldCode", c, fieldCode[ch])
  endtask : wait_code
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  // Words seen on the link must carry the stored code with enable set.
  always @(posedge mclk) begin
    if (steady && link.pointValid && link.pointReady) begin
      `CHK("pointWord", {1'b1, expCode[seenSel]}, seenWord)
    end
  end
  initial begin
    #(40 * 40000);
    failures++;
    $display("Error watchdog expected done seen hang");
    stop_test();
  end
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [CODE_W-1:0] nc;
    logic [15:0] sc;
    int n;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    axi_rd(REG_CTRL, d, r);
    `CHK("ctrlReset", CTRL_RESET, d)
    axi_rd(8'h40, d, r);
    `CHK("rdResp", RESP_SLVERR, r)
    axi_wr(8'h40, 32'h1, 4'hf, r);
    `CHK("wrResp", RESP_SLVERR, r)
    $display("test registers done");
    for (int i = 0; i < CH; i++) begin
      seed = lfsr(seed);
      expCode[i] = (i == 0) ? 12'hfff : (i == 7) ? 12'h800 : seed[11:0];
      axi_wr(data_addr(i), {20'hfffff, expCode[i]}, 4'hf, r);
    end
    `CHK("wrOkay", RESP_OKAY, r)
    axi_wr(data_addr(2), 32'hffff_ff5a, 4'h1, r);
    expCode[2] = {expCode[2][11:8], 8'h5a};
    axi_rd(data_addr(2), d, r);
    `CHK("dataRead", {20'h0, expCode[2]}, d)
    axi_wr(REG_CTRL, ctrl_word(1'b1, 1'b1, 1'b1, 3'h7), 4'hf, r);
    for (int i = 0; i < CH; i++) wait_code(i, expCode[i], 2 * RFR + SCN + 20);
    `CHK("outputsOn", 1'b1, outputsOn)
    steady <= 1'b1;
    // The two status samples lie exactly two scan periods apart, so the counter
    // must have stepped by two.
    axi_rd(REG_STATUS, d, r);
    sc = d[STAT_SCAN_LSB +: 16];
    repeat (2 * SCN - 2) @(posedge mclk);
    axi_rd(REG_STATUS, d, r);
    `CHK("scanCount", sc + 16'h0002, d[STAT_SCAN_LSB +: 16])
    `CHK("rdOkay", RESP_OKAY, r)
    steady <= 1'b0;
    $display("test pointer done");
    axi_wr(REG_CTRL, ctrl_word(1'b1, 1'b0, 1'b1, 3'h0), 4'hf, r);
    seed = lfsr(seed);
    nc = expCode[1] ^ (seed[11:0] | 12'h001);
    axi_wr(data_addr(1), {20'h0, nc}, 4'hf, r);
    axi_wr(data_addr(0), 32'h0000_0123, 4'hf, r);
    wait_code(0, 12'h123, LAT);
    repeat (3 * SCN) @(posedge mclk);
    `CHK("heldCode", expCode[1], fieldCode[1])
    axi_wr(REG_CTRL, ctrl_word(1'b1, 1'b0, 1'b1, 3'h7), 4'hf, r);
    wait_code(1, nc, LAT);
    expCode[1] = nc;
    expCode[0] = 12'h123;
    $display("test multiplex done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      rangeJumperIn <= seed[0];
      repeat (3) @(posedge mclk);
      `CHK("rangeTenVolt", ~seed[0], rangeTenVolt)
    end
    while (refreshTick !== 1'b1) @(posedge mclk);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (refreshTick !== 1'b1 && n < 4 * RFR);
    `CHK("refreshGap", RFR, n)
    $display("test range done");
    axi_wr(REG_CTRL, ctrl_word(1'b1, 1'b1, 1'b0, 3'h7), 4'hf, r);
    for (int i = 0; i < CH; i++) wait_code(i, 12'h000, LAT);
    `CHK("outputsOn", 1'b0, outputsOn)
    axi_wr(REG_CTRL, ctrl_word(1'b1, 1'b1, 1'b1, 3'h7), 4'hf, r);
    wait_code(5, expCode[5], LAT);
    $display("test enable done");
    stop_test();
  end
endmodule : daco_test
